// ### rtl/pfc_defines.svh
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// register byte offsets
`define PFC_OFF_CTRL      12'h000
`define PFC_OFF_STATUS    12'h004
`define PFC_OFF_PRIO_BASE 12'h020
// control register fields
`define PFC_CTRL_TX_EN    0
`define PFC_CTRL_RX_EN    1
`define PFC_CTRL_XON_EN   2
`define PFC_CTRL_LEG_EN   3
`define PFC_CTRL_PEN_LSB  8
// per-priority register fields: pause in [15:0], refresh in [31:16]
`define PFC_PRIO_PAUSE_LSB 0
`define PFC_PRIO_REFR_LSB  16
// reset values
`define PFC_CTRL_RST      32'h0000_ff01
`define PFC_PRIO_RST      32'hff00_ffff
// frame identification
`define PFC_CTRL_TYPE     16'h8808
`define PFC_OPCODE        16'h0101
// quantum: 512 bit times = 51.2 ns at 10 Gb/s; 8 cycles of 64-bit core words per quantum
`define PFC_QUANTUM_BITS  512
`define PFC_WORD_BITS     64
`define PFC_CYC_PER_QUANT (`PFC_QUANTUM_BITS / `PFC_WORD_BITS)

`endif

// ### rtl/pfc_pkg.sv
package pfc_pkg;
   // outgoing frame fields
   typedef struct packed {
      logic [15:0]       class_en;
      logic [7:0][15:0]  quanta;
   } pfc_frame_s;
   // decoded received control frame fields
   typedef struct packed {
      logic [15:0]       len_type;
      logic [15:0]       opcode;
      logic [15:0]       class_en;
      logic [7:0][15:0]  quanta;
   } pfc_rx_s;
   typedef enum logic [1:0] {PFC_IDLE, PFC_PEND} pfc_tx_st_e;
endpackage

// ### rtl/pfc_rx_timer.sv
`timescale 1ns/100ps
`include "pfc_defines.svh"
// one priority's pause timer: counts quanta down, pause high while non-zero
module pfc_rx_timer
(
   // clocking
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // load
   input  wire logic        load_i,
   input  wire logic [15:0] quanta_i,
   // indication
   output logic             pause_o
);
   logic [15:0] count;
   logic [2:0]  sub;
   logic [15:0] next_count;
   logic [2:0]  next_sub;

   always_comb
   begin
      next_count = count;
      next_sub   = sub;
      if (load_i)
      begin
         next_count = quanta_i;
         next_sub   = 3'h0;
      end
      else if (count != 16'h0)
      begin
         if (sub == 3'(`PFC_CYC_PER_QUANT - 1))
         begin
            next_sub   = 3'h0;
            next_count = count - 16'h1;
         end
         else
            next_sub = sub + 3'h1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         count <= 16'h0;
         sub   <= 3'h0;
      end
      else if (ce_i)
      begin
         count <= next_count;
         sub   <= next_sub;
      end
   end

   assign pause_o = (count != 16'h0);
endmodule // pfc_rx_timer

// ### rtl/pfc_request_generator.sv
`timescale 1ns/100ps
`include "pfc_defines.svh"
// Contract
// - tx and rx priority flow control each have their own enable bit.
// - eight separate pause indication outputs, one per priority.
// - frame enable vector is 16 bits, upper eight always zero.
// - eight 16-bit quanta, priority zero first.
// - one quantum is 512 bit times, 51.2 ns.
// - frames only with tx enabled and the priority's own enable set; the code still sends an xon for a held priority whose enable is cleared.
// - request held over one cycle is xoff, refreshed in every frame.
// - single-cycle pulse yields one frame, no automatic refresh.
// - held request resends when quanta count reaches its refresh value.
// - each priority has one register holding pause and refresh values.
// - with auto xon, releasing a held request sends zero quanta frame.
// - every frame carries all active priorities and restarts quanta count.
// - new request during another held one sends frame enabling both.
// - refresh frames enable only priorities whose requests are high.
// - xon frame keeps other active priorities with normal quanta.
// - with internal flow control off, client frames pass as data.
// - control frame type 88-08 and priority opcode identify pfc frames.
// - received quanta load per-priority counters; zero clears pause at once.
module pfc_request_generator
(
   // clock, reset, enable
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // apb slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [11:0]         paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic                     pready_o,
   output logic [31:0]              prdata_o,
   output logic                     pslverr_o,
   // client requests, core-clock synchronous
   input  wire logic [7:0]          tx_req_i,
   // frame request to transmitter
   output logic                     frame_valid_o,
   input  wire logic                frame_ready_i,
   output pfc_pkg::pfc_frame_s      frame_o,
   // client frames pass as data when internal control is off
   output logic                     client_ctrl_ok_o,
   // received control frame
   input  wire logic                rx_valid_i,
   input  wire pfc_pkg::pfc_rx_s    rx_frame_i,
   // per-priority pause indications
   output logic [7:0]               pause_o
);
   // configuration
   logic [31:0]      ctrl;
   logic [7:0][31:0] prio_cfg;
   logic [31:0]      next_ctrl;
   logic [7:0][31:0] next_prio_cfg;
   logic [31:0]      next_prdata;
   // transmit state
   pfc_pkg::pfc_tx_st_e state;
   pfc_pkg::pfc_tx_st_e next_state;
   logic [7:0]       req_d;
   logic [7:0]       held;
   logic [7:0]       xon_pend;
   logic [7:0]       new_pend;
   logic [15:0]      qcount;
   logic [2:0]       qsub;
   logic             counting;
   pfc_pkg::pfc_frame_s frame;
   logic [7:0]       next_req_d;
   logic [7:0]       next_held;
   logic [7:0]       next_xon_pend;
   logic [7:0]       next_new_pend;
   logic [15:0]      next_qcount;
   logic [2:0]       next_qsub;
   logic             next_counting;
   pfc_pkg::pfc_frame_s next_frame;
   // combinational helpers
   logic             tx_on;
   logic [7:0]       pen;
   logic [7:0]       req;
   logic [7:0]       rise;
   logic [7:0]       release_ev;
   logic             refresh_hit;
   logic             trigger;
   logic             wr_en;
   logic             rd_en;
   logic             addr_ok;
   logic [7:0]       rx_load;
   logic             rx_ok;
   logic             take;

   function automatic logic [15:0] pause_of(input logic [31:0] cfg);
      pause_of = cfg[`PFC_PRIO_PAUSE_LSB +: 16];
   endfunction

   function automatic logic [15:0] refr_of(input logic [31:0] cfg);
      refr_of = cfg[`PFC_PRIO_REFR_LSB +: 16];
   endfunction

   function automatic logic prio_hit(input logic [11:0] a);
      prio_hit = (a >= `PFC_OFF_PRIO_BASE) && (a < `PFC_OFF_PRIO_BASE + 12'h020)
                 && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [2:0] prio_idx(input logic [11:0] a);
      prio_idx = a[4:2];
   endfunction

   function automatic logic is_ctrl(input logic [11:0] a);
      is_ctrl = (a == `PFC_OFF_CTRL);
   endfunction

   // apb: zero wait state, error on unmapped
   assign wr_en    = psel_i && penable_i && pwrite_i;
   assign rd_en    = psel_i && !pwrite_i;
   assign addr_ok  = is_ctrl(paddr_i) || (paddr_i == `PFC_OFF_STATUS)
                     || prio_hit(paddr_i);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;

   always_comb
   begin
      next_ctrl     = ctrl;
      next_prio_cfg = prio_cfg;
      next_prdata   = prdata_o;
      if (wr_en && is_ctrl(paddr_i))
         next_ctrl = pwdata_i & 32'h0000_ff0f;
      else if (wr_en && prio_hit(paddr_i))
         next_prio_cfg[prio_idx(paddr_i)] = pwdata_i;
      // latched in the setup phase so it already stands at the access edge
      if (rd_en && !penable_i)
      begin
         if (is_ctrl(paddr_i))
            next_prdata = ctrl;
         else if (paddr_i == `PFC_OFF_STATUS)
            next_prdata = {15'h0, state == pfc_pkg::PFC_PEND, held, pause_o};
         else if (prio_hit(paddr_i))
            next_prdata = prio_cfg[prio_idx(paddr_i)];
         else
            next_prdata = 32'h0;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ctrl     <= `PFC_CTRL_RST;
         prio_cfg <= {8{`PFC_PRIO_RST}};
         prdata_o <= 32'h0;
      end
      else if (ce_i)
      begin
         ctrl     <= next_ctrl;
         prio_cfg <= next_prio_cfg;
         prdata_o <= next_prdata;
      end
   end

   // legacy pause left enabled together with pfc is unsupported; tx is held off
   assign tx_on = ctrl[`PFC_CTRL_TX_EN] && !ctrl[`PFC_CTRL_LEG_EN];
   assign pen   = ctrl[`PFC_CTRL_PEN_LSB +: 8];
   assign req   = tx_on ? (tx_req_i & pen) : 8'h00;
   assign rise  = req & ~req_d;
   assign release_ev = held & ~req & {8{ctrl[`PFC_CTRL_XON_EN]}};
   assign client_ctrl_ok_o = !ctrl[`PFC_CTRL_TX_EN];

   // refresh when the count reaches the lowest refresh value among held
   always_comb
   begin
      refresh_hit = 1'b0;
      for (int i = 0; i < 8; i++)
         if (held[i] && req[i] && counting && qcount == refr_of(prio_cfg[i]))
            refresh_hit = 1'b1;
   end

   assign trigger = (|rise) || (|release_ev) || refresh_hit;
   assign take    = frame_valid_o && frame_ready_i;

   always_comb
   begin
      next_state    = state;
      next_req_d    = req;
      next_new_pend = new_pend | rise;
      next_xon_pend = xon_pend | release_ev;
      // held marks a request that stayed high past its first cycle
      next_held     = (held | (req & req_d)) & req;
      next_frame    = frame;
      if (state == pfc_pkg::PFC_IDLE && trigger)
         next_state = pfc_pkg::PFC_PEND;
      else if (take)
      begin
         // a refresh hit still standing rode in the frame just taken;
         // only fresh edges keep the generator pending
         next_state    = (|rise || |release_ev) ? pfc_pkg::PFC_PEND : pfc_pkg::PFC_IDLE;
         next_new_pend = rise;
         next_xon_pend = release_ev;
      end
      if (!tx_on)
      begin
         next_state    = pfc_pkg::PFC_IDLE;
         next_new_pend = 8'h00;
         next_xon_pend = 8'h00;
      end
      // frame contents track live requests until taken
      next_frame.class_en = 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
         next_frame.quanta[i] = 16'h0000;
         if (req[i] || next_new_pend[i])
         begin
            next_frame.class_en[i] = 1'b1;
            next_frame.quanta[i]   = pause_of(prio_cfg[i]);
         end
         else if (next_xon_pend[i])
            next_frame.class_en[i] = 1'b1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state    <= pfc_pkg::PFC_IDLE;
         req_d    <= 8'h00;
         held     <= 8'h00;
         xon_pend <= 8'h00;
         new_pend <= 8'h00;
         frame    <= '0;
      end
      else if (ce_i)
      begin
         state    <= next_state;
         req_d    <= next_req_d;
         held     <= next_held;
         xon_pend <= next_xon_pend;
         new_pend <= next_new_pend;
         frame    <= next_frame;
      end
   end

   // refresh quanta count; a take restarts it, held state decides whether it runs
   always_comb
   begin
      next_qcount   = qcount;
      next_qsub     = qsub;
      next_counting = counting;
      if (counting)
      begin
         if (qsub == 3'(`PFC_CYC_PER_QUANT - 1))
         begin
            next_qsub   = 3'h0;
            next_qcount = qcount + 16'h1;
         end
         else
            next_qsub = qsub + 3'h1;
      end
      if (take)
      begin
         next_qcount   = 16'h0;
         next_qsub     = 3'h0;
         next_counting = |next_held;
      end
      if (!tx_on)
         next_counting = 1'b0;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         qcount   <= 16'h0;
         qsub     <= 3'h0;
         counting <= 1'b0;
      end
      else if (ce_i)
      begin
         qcount   <= next_qcount;
         qsub     <= next_qsub;
         counting <= next_counting;
      end
   end

   assign frame_valid_o = (state == pfc_pkg::PFC_PEND);
   assign frame_o       = frame;

   // receive: type and opcode checked here, other frame checks upstream
   assign rx_ok = rx_valid_i && ctrl[`PFC_CTRL_RX_EN]
                  && rx_frame_i.len_type == `PFC_CTRL_TYPE
                  && rx_frame_i.opcode == `PFC_OPCODE;
   assign rx_load = {8{rx_ok}} & rx_frame_i.class_en[7:0];

   for (genvar g = 0; g < 8; g++)
   begin : g_rx
      pfc_rx_timer u_timer
      (
         .mclk_i   (mclk_i),
         .rst_i    (rst_i),
         .ce_i     (ce_i),
         .load_i   (rx_load[g]),
         .quanta_i (rx_frame_i.quanta[g]),
         .pause_o  (pause_o[g])
      );
   end
endmodule // pfc_request_generator

// ### test/pfc_req_monitor.sv
`timescale 1ns/100ps
module pfc_req_monitor
(
   // clocking
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // apb
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic [11:0]         paddr_i,
   input  wire logic                pready_o,
   input  wire logic                pslverr_o,
   // frames and pause
   input  wire logic [7:0]          tx_req_i,
   input  wire logic                frame_valid_o,
   input  wire logic                frame_ready_i,
   input  wire pfc_pkg::pfc_frame_s frame_o,
   input  wire logic                rx_valid_i,
   input  wire logic [7:0]          pause_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_access;
      psel_i && penable_i;
   endsequence
   sequence s_taken;
      frame_valid_o && frame_ready_i;
   endsequence
   AST_PREADY: assert property (s_access |-> pready_o)
      else $error("apb access not ready");
   AST_SLVERR_HOLE: assert property (s_access ##0 paddr_i == 12'h100 |-> pslverr_o)
      else $error("unmapped access not refused");
   AST_SLVERR_CTRL: assert property (s_access ##0 paddr_i == 12'h000 |-> !pslverr_o)
      else $error("control access refused");
   AST_UPPER_ZERO: assert property (frame_valid_o |-> frame_o.class_en[15:8] == 8'h00)
      else $error("upper enable bits set");
   AST_VALID_HOLD: assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o)
      else $error("pending frame dropped");
   // a request edge at the take edge may start the next frame at once
   AST_TAKE_DROP: assert property (s_taken ##0 tx_req_i == $past(tx_req_i)
      |=> !frame_valid_o)
      else $error("frame repeated without cause");
   AST_PAUSE_CAUSE: assert property ((pause_o & ~$past(pause_o)) != 8'h00
      |-> $past(rx_valid_i))
      else $error("pause raised without frame");
   AST_CE_FREEZE: assert property (!ce_i |=> $stable(pause_o) && $stable(frame_valid_o))
      else $error("state moved while disabled");
endmodule // pfc_req_monitor

bind pfc_request_generator pfc_req_monitor u_pfc_req_monitor
(
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .paddr_i(paddr_i),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .tx_req_i(tx_req_i),
   .frame_valid_o(frame_valid_o),
   .frame_ready_i(frame_ready_i),
   .frame_o(frame_o),
   .rx_valid_i(rx_valid_i),
   .pause_o(pause_o)
);

// ### test/pfc_link_model.sv
`timescale 1ns/100ps
// transmitter side: takes each frame after a programmable stall
module pfc_link_model
(
   // clocking
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   // frame handshake
   input  wire logic                frame_valid_i,
   input  wire pfc_pkg::pfc_frame_s frame_i,
   input  wire logic [3:0]          stall_i,
   output logic                     frame_ready_o,
   // last frame taken and take count
   output pfc_pkg::pfc_frame_s      last_o,
   output logic [7:0]               taken_o
);
   logic [3:0]          wait_q;
   logic [3:0]          next_wait;
   pfc_pkg::pfc_frame_s next_last;
   logic [7:0]          next_taken;

   assign frame_ready_o = frame_valid_i && (wait_q >= stall_i);

   always_comb
   begin
      next_wait = frame_valid_i ? wait_q + 4'h1 : 4'h0;
      next_last = last_o;
      next_taken = taken_o;
      if (frame_ready_o)
      begin
         next_wait = 4'h0;
         next_last = frame_i;
         next_taken = taken_o + 8'h01;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      wait_q <= rst_i ? 4'h0 : next_wait;
      last_o <= rst_i ? '0 : next_last;
      taken_o <= rst_i ? 8'h00 : next_taken;
   end
endmodule // pfc_link_model

// ### test/tb_pfc_request_generator.sv
`timescale 1ns/100ps
module tb_pfc_request_generator;
   logic                mclk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
   logic                psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
   logic [11:0]         paddr_i = 12'h000;
   logic [31:0]         pwdata_i = 32'h0, prdata_o, rd;
   logic                pready_o, pslverr_o, err, frame_valid_o, frame_ready_i;
   logic                client_ctrl_ok_o, rx_valid_i = 1'h0;
   logic [7:0]          tx_req_i = 8'h00, pause_o, taken;
   logic [3:0]          stall = 4'h0;
   pfc_pkg::pfc_frame_s frame_o, last;
   pfc_pkg::pfc_rx_s    rx_frame_i = '0;
   int                  n, fails = 0, checks = 0;

   always #12.5 mclk_i = ~mclk_i;

   pfc_request_generator u_pfc_request_generator
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .tx_req_i(tx_req_i),
      .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i),
      .frame_o(frame_o), .client_ctrl_ok_o(client_ctrl_ok_o),
      .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .pause_o(pause_o)
   );
   pfc_link_model u_pfc_link_model
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .frame_valid_i(frame_valid_o),
      .frame_i(frame_o), .stall_i(stall), .frame_ready_o(frame_ready_i),
      .last_o(last), .taken_o(taken)
   );

   task automatic report_and_stop;
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang;
      fails++;
      report_and_stop();
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do
      begin
         @(posedge mclk_i);
         k++;
      end
      while (pready_o !== 1'h1 && k < 20);
      if (k == 20)
         hang();
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
      // idle edge: a following call never re-raises psel in this step
      @(posedge mclk_i);
   endtask
   task automatic wt;
      logic [7:0] t0;
      t0 = taken;
      n = 0;
      while (taken === t0 && n < 400)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 400)
         hang();
   endtask
   task automatic quiet(input int c);
      logic [7:0] t0;
      t0 = taken;
      repeat (c) @(posedge mclk_i);
      chk(taken, t0);
   endtask
   task automatic rx(input logic [31:0] to, input logic [15:0] q);
      rx_frame_i.len_type <= to[31:16];
      rx_frame_i.opcode <= to[15:0];
      rx_frame_i.class_en <= 16'h0001;
      rx_frame_i.quanta[0] <= q;
      rx_valid_i <= 1'h1;
      @(posedge mclk_i);
      rx_valid_i <= 1'h0;
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic t_regs;
      apb(1'h0, 12'h000, 32'h0);
      chk(rd, 32'h0000_ff01);
      apb(1'h0, 12'h020, 32'h0);
      chk(rd, 32'hff00_ffff);
      apb(1'h0, 12'h100, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'h1, 12'h020, 32'h0002_00ff);
      apb(1'h0, 12'h020, 32'h0);
      chk(rd, 32'h0002_00ff);
   endtask
   task automatic t_xoff;
      apb(1'h1, 12'h028, 32'h0002_0222);
      apb(1'h1, 12'h038, 32'hff00_0666);
      apb(1'h1, 12'h000, 32'h0000_ff05);
      chk(client_ctrl_ok_o, 1'h0);
      tx_req_i[0] <= 1'h1;
      wt();
      chk({last.class_en, last.quanta[0]}, 32'h0001_00ff);
      tx_req_i[2] <= 1'h1;
      @(posedge mclk_i);
      tx_req_i[2] <= 1'h0;
      wt();
      chk({last.class_en, last.quanta[2]}, 32'h0005_0222);
      wt();
      chk({last.class_en, last.quanta[0]}, 32'h0001_00ff);
      chk(n > 16 && n < 20, 1'h1);
      tx_req_i[6] <= 1'h1;
      wt();
      chk({last.class_en, last.quanta[6]}, 32'h0041_0666);
      // slow taker so the release and the new request meet in one frame
      stall <= 4'h6;
      tx_req_i[0] <= 1'h0;
      @(posedge mclk_i);
      tx_req_i[3] <= 1'h1;
      wt();
      chk({last.class_en, last.quanta[0]}, 32'h0049_0000);
      chk(last.quanta[6], 16'h0666);
      stall <= 4'h0;
      quiet(12);
      tx_req_i <= 8'h00;
      wt();
      chk({last.class_en, last.quanta[3]}, 32'h0048_0000);
   endtask
   task automatic t_gate;
      // legacy pause set alongside pfc keeps the generator silent
      apb(1'h1, 12'h000, 32'h0000_ff09);
      tx_req_i[0] <= 1'h1;
      quiet(30);
      apb(1'h1, 12'h000, 32'h0000_fe01);
      quiet(30);
      tx_req_i[0] <= 1'h0;
      apb(1'h1, 12'h000, 32'h0000_ff00);
      @(posedge mclk_i);
      chk(client_ctrl_ok_o, 1'h1);
      tx_req_i[1] <= 1'h1;
      quiet(30);
      tx_req_i[1] <= 1'h0;
   endtask
   task automatic t_rx;
      rx(32'h8808_0101, 16'h0002);
      chk(pause_o, 8'h00);
      apb(1'h1, 12'h000, 32'h0000_ff02);
      rx(32'h8809_0101, 16'h0002);
      chk(pause_o, 8'h00);
      rx(32'h8808_0001, 16'h0002);
      chk(pause_o, 8'h00);
      rx(32'h8808_0101, 16'h0002);
      chk(pause_o, 8'h01);
      n = 0;
      while (pause_o[0] === 1'h1 && n < 100)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 100)
         hang();
      chk(n > 12 && n < 17, 1'h1);
      rx(32'h8808_0101, 16'hffff);
      ce_i <= 1'h0;
      repeat (4) @(posedge mclk_i);
      ce_i <= 1'h1;
      chk(pause_o, 8'h01);
      rx(32'h8808_0101, 16'h0000);
      chk(pause_o, 8'h00);
   endtask

   initial
   begin
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'h0;
      t_regs();
      t_xoff();
      t_gate();
      t_rx();
      report_and_stop();
   end
endmodule // tb_pfc_request_generator
